// ==== logic/mie_core.sv ====
// Instruction execute core with program memory, file, stack and register port
//
// Summary of operation
// - Loading a control-page register copies the work register into page address 6..15 in one cycle, flags untouched.
// - Reading a control-page register copies page address 6..15 into the work register in one cycle, flags untouched.
// - The long call pushes the next address and loads the 9-bit operand into the program counter, in two cycles.
// - The long jump loads the 9-bit operand into the program counter without the stack, two cycles, no flags.
// - Loading a literal puts the 8-bit operand into the work register in one cycle with flags untouched.
// - The file copy moves a file register to the work register (dest 0) or to itself (dest 1) and updates zero.
// - The interrupt return pops the stack into the program counter and sets the global interrupt enable, two cycles.
// - The literal return loads the work register, pops the program counter and sets the global enable, two cycles.
// - Rotate right passes carry into bit 7 and bit 0 into carry, result to the chosen destination.
// - Subtract forms file minus work register and updates zero, half carry and carry.
// - Nibble exchange swaps the file register halves into the chosen destination in one cycle, no flags.
// - Table read fetches the word at table pointer bit 0 and work register, low byte into work, two cycles.
// - The same table read puts the upper six word bits into bits 5..0 of the table high data register.
// - Timer mode load copies the work register into the timer mode register in one cycle, flags untouched.
// - Exclusive-OR of work and file register goes to work (dest 0) or file (dest 1) and updates zero.
`timescale 1ns/1ps
`default_nettype none
module mie_core
  import mie_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic [BUS_AW-1:0] reg_addr,
  input  wire logic [BUS_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [BUS_DW-1:0] reg_rdata,
  output logic                   global_irq_enable,
  output logic      [DATA_W-1:0] timer_mode_reg
);

  typedef enum logic [0:0] {ST_EXEC, ST_SECOND} mie_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [WORD_W-1:0] rom_mem   [ROM_DEPTH];
  logic [DATA_W-1:0] file_mem  [FILE_DEPTH];
  logic [DATA_W-1:0] cpage_mem [CP_DEPTH];
  logic [PC_W-1:0]   stack_mem [STACK_DEPTH];

  mie_state_t        state_ff, nxt_state;
  logic [PC_W-1:0]   pc_ff, nxt_pc;
  logic [DATA_W-1:0] work_ff, nxt_work;
  mie_flags_t        flags_ff, nxt_flags;
  logic              gie_ff, nxt_gie;
  logic [SP_W-1:0]   sp_ff, nxt_sp;
  logic [5:0]        table_high_data_reg_ff, nxt_table_high_data_reg;
  logic [DATA_W-1:0] tmode_ff, nxt_tmode;
  logic              table_ff, nxt_table;

  logic              run_ff, nxt_run;
  logic [PC_W-1:0]   paddr_ff, nxt_paddr;
  logic [DATA_W-1:0] table_high_pointer_ff, nxt_table_high_pointer;
  logic [BUS_DW-1:0] rdata_ff, nxt_rdata;

  // Memory write requests from the core and the port
  logic              file_we;
  logic [5:0]        file_wa;
  logic [DATA_W-1:0] file_wd;
  logic              cp_we;
  logic              stk_we;
  logic [PC_W-1:0]   stk_wd;
  logic              rom_we;

  mie_dec_t          dec;
  logic [DATA_W-1:0] fval;
  logic [DATA_W-1:0] res;
  logic [8:0]        diff;
  logic [4:0]        ldiff;
  logic [WORD_W-1:0] tword;
  logic              cp_ok;

  assign dec   = mie_decode(rom_mem[pc_ff]);
  assign fval  = file_mem[dec.faddr];
  assign cp_ok = (dec.cpaddr >= CP_LO) && (dec.cpaddr <= CP_HI);
  assign tword = rom_mem[{table_high_pointer_ff[0], work_ff}];
  assign diff  = {1'b0, fval} - {1'b0, work_ff};
  assign ldiff = {1'b0, fval[3:0]} - {1'b0, work_ff[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Execute: next state of the core
  always_comb begin
    nxt_state = ST_EXEC;
    nxt_pc    = pc_ff;
    nxt_work  = work_ff;
    nxt_flags = flags_ff;
    nxt_gie   = gie_ff;
    nxt_sp    = sp_ff;
    nxt_table_high_data_reg  = table_high_data_reg_ff;
    nxt_tmode = tmode_ff;
    nxt_table = 1'b0;
    file_we   = 1'b0;
    file_wa   = dec.faddr;
    file_wd   = BYTE_RST;
    cp_we     = 1'b0;
    stk_we    = 1'b0;
    stk_wd    = pc_ff + PC_ONE;
    res       = BYTE_RST;
    if (!run_ff) begin
      nxt_state = state_ff;
    end else if (state_ff == ST_SECOND) begin
      // Second cycle: the prefetched word is dropped; table data lands here
      if (table_ff) begin
        nxt_work = tword[7:0];
        nxt_table_high_data_reg = tword[13:8];
      end
    end else begin
      nxt_pc = pc_ff + PC_ONE;
      case (dec.op)
        OP_CPWR: begin
          cp_we = cp_ok;
        end
        OP_CPRD: begin
          nxt_work = cp_ok ? cpage_mem[dec.cpaddr] : BYTE_RST;
        end
        OP_LONG_CALL_OP: begin
          stk_we    = 1'b1;
          nxt_sp    = sp_ff + SP_ONE;
          nxt_pc    = dec.adr;
          nxt_state = ST_SECOND;
        end
        OP_LJUMP: begin
          nxt_pc    = dec.adr;
          nxt_state = ST_SECOND;
        end
        OP_LIT: begin
          nxt_work = dec.lit;
        end
        OP_RETI, OP_RETLIT: begin
          nxt_sp    = sp_ff - SP_ONE;
          nxt_pc    = stack_mem[sp_ff - SP_ONE];
          nxt_gie   = 1'b1;
          nxt_state = ST_SECOND;
          if (dec.op == OP_RETLIT) nxt_work = dec.lit;
        end
        OP_COPY, OP_ROTR, OP_SUB, OP_SWAP, OP_XOR: begin
          case (dec.op)
            OP_COPY: begin
              res         = fval;
              nxt_flags.z = (fval == BYTE_RST);
            end
            OP_ROTR: begin
              res         = {flags_ff.c, fval[7:1]};
              nxt_flags.c = fval[0];
            end
            OP_SUB: begin
              res          = diff[7:0];
              nxt_flags.z  = (diff[7:0] == BYTE_RST);
              nxt_flags.c  = ~diff[8];
              nxt_flags.dc = ~ldiff[4];
            end
            OP_SWAP: begin
              res = {fval[3:0], fval[7:4]};
            end
            default: begin
              res         = fval ^ work_ff;
              nxt_flags.z = (res == BYTE_RST);
            end
          endcase
          // Destination bit picks work register or file
          if (dec.dest) begin
            file_we = 1'b1;
            file_wd = res;
          end else begin
            nxt_work = res;
          end
        end
        OP_TABLE: begin
          // memory read finishes in the second cycle
          nxt_table = 1'b1;
          nxt_state = ST_SECOND;
        end
        OP_TMODE: begin
          nxt_tmode = work_ff;
        end
        default: begin
          nxt_state = ST_EXEC;
        end
      endcase
    end
  end

  // Core registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_EXEC;
      pc_ff    <= PC_RST;
      work_ff  <= BYTE_RST;
      flags_ff <= '0;
      gie_ff   <= 1'b0;
      sp_ff    <= '0;
      table_high_data_reg_ff  <= '0;
      tmode_ff <= BYTE_RST;
      table_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      work_ff  <= nxt_work;
      flags_ff <= nxt_flags;
      gie_ff   <= nxt_gie;
      sp_ff    <= nxt_sp;
      table_high_data_reg_ff  <= nxt_table_high_data_reg;
      tmode_ff <= nxt_tmode;
      table_ff <= nxt_table;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program memory and stack keep their contents through reset
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (stk_we) stack_mem[sp_ff] <= stk_wd;
      if (rom_we) rom_mem[paddr_ff] <= reg_wdata[WORD_W-1:0];
    end
  end

  // Control page and file clear on reset; the subset cannot store the work
  // register into the file, so an unknown file would poison every result
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CP_DEPTH; i++) begin
        cpage_mem[i] <= BYTE_RST;
      end
      for (int j = 0; j < FILE_DEPTH; j++) begin
        file_mem[j] <= BYTE_RST;
      end
    end else if (clk_en) begin
      if (cp_we) cpage_mem[dec.cpaddr] <= work_ff;
      if (file_we) file_mem[file_wa] <= file_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port: program load is only taken while halted, so a running
  // program never sees its own code change under it
  always_comb begin
    nxt_run   = run_ff;
    nxt_paddr = paddr_ff;
    nxt_table_high_pointer  = table_high_pointer_ff;
    nxt_rdata = BUS_ZERO;
    rom_we    = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL:  nxt_run = reg_wdata[0];
        OFS_PADDR: nxt_paddr = reg_wdata[PC_W-1:0];
        OFS_PDATA: begin
          rom_we    = ~run_ff;
          nxt_paddr = run_ff ? paddr_ff : paddr_ff + PC_ONE;
        end
        OFS_TABLE_HIGH_POINTER:  nxt_table_high_pointer = reg_wdata[DATA_W-1:0];
        default:   nxt_run = run_ff;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:  nxt_rdata = {15'h0000, run_ff};
        OFS_PADDR: nxt_rdata = {7'h00, paddr_ff};
        OFS_PDATA: nxt_rdata = {2'h0, rom_mem[paddr_ff]};
        OFS_WORK:  nxt_rdata = {8'h00, work_ff};
        OFS_PC:    nxt_rdata = {7'h00, pc_ff};
        OFS_FLAGS: nxt_rdata = {12'h000, gie_ff, flags_ff};
        OFS_TABLE_HIGH_POINTER:  nxt_rdata = {8'h00, table_high_pointer_ff};
        OFS_TABLE_HIGH_DATA_REG:  nxt_rdata = {10'h000, table_high_data_reg_ff};
        OFS_TMODE: nxt_rdata = {8'h00, tmode_ff};
        default:   nxt_rdata = BUS_ZERO;
      endcase
    end
  end

  // Port registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff   <= 1'b0;
      paddr_ff <= PC_RST;
      table_high_pointer_ff  <= BYTE_RST;
      rdata_ff <= BUS_ZERO;
    end else if (clk_en) begin
      run_ff   <= nxt_run;
      paddr_ff <= nxt_paddr;
      table_high_pointer_ff  <= nxt_table_high_pointer;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata         = rdata_ff;
  assign global_irq_enable = gie_ff;
  assign timer_mode_reg    = tmode_ff;

endmodule
`default_nettype wire

// ==== logic/mie_pkg.sv ====
// Constants, types and instruction decode for the instruction execute core
package mie_pkg;
  localparam int PC_W        = 9;
  localparam int ROM_DEPTH   = 512;
  localparam int WORD_W      = 14;
  localparam int DATA_W      = 8;
  localparam int FILE_DEPTH  = 64;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W        = 2;
  localparam int CP_DEPTH    = 16;
  localparam logic [3:0] CP_LO = 4'h6;
  localparam logic [3:0] CP_HI = 4'hF;
  localparam logic [SP_W-1:0] SP_ONE = 2'h1;
  localparam logic [PC_W-1:0] PC_ONE = 9'h001;
  localparam logic [PC_W-1:0] PC_RST = 9'h000;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  // Encodings of the executed subset
  localparam logic [4:0] ENC_LONG_CALL_OP  = 5'h1E;   // [13:9]
  localparam logic [4:0] ENC_LJUMP  = 5'h1F;   // [13:9]
  localparam logic [5:0] ENC_LIT    = 6'h30;   // [13:8]
  localparam logic [5:0] ENC_RETLIT = 6'h31;   // [13:8]
  localparam logic [6:0] ENC_COPY   = 7'h08;   // [13:7]
  localparam logic [6:0] ENC_ROTR   = 7'h09;
  localparam logic [6:0] ENC_SUB    = 7'h0A;
  localparam logic [6:0] ENC_SWAP   = 7'h0B;
  localparam logic [6:0] ENC_XOR    = 7'h0C;
  localparam logic [9:0] ENC_CPWR   = 10'h001; // [13:4]
  localparam logic [9:0] ENC_CPRD   = 10'h002; // [13:4]
  localparam logic [WORD_W-1:0] ENC_RETI  = 14'h0001;
  localparam logic [WORD_W-1:0] ENC_TABLE = 14'h0002;
  localparam logic [WORD_W-1:0] ENC_TMODE = 14'h0003;
  // Register port map (word offsets)
  localparam int BUS_AW = 4;
  localparam int BUS_DW = 16;
  localparam logic [BUS_AW-1:0] OFS_CTRL  = 4'h0;
  localparam logic [BUS_AW-1:0] OFS_PADDR = 4'h1;
  localparam logic [BUS_AW-1:0] OFS_PDATA = 4'h2;
  localparam logic [BUS_AW-1:0] OFS_WORK  = 4'h3;
  localparam logic [BUS_AW-1:0] OFS_PC    = 4'h4;
  localparam logic [BUS_AW-1:0] OFS_FLAGS = 4'h5;
  localparam logic [BUS_AW-1:0] OFS_TABLE_HIGH_POINTER  = 4'h6;
  localparam logic [BUS_AW-1:0] OFS_TABLE_HIGH_DATA_REG  = 4'h7;
  localparam logic [BUS_AW-1:0] OFS_TMODE = 4'h8;
  localparam logic [BUS_DW-1:0] BUS_ZERO  = 16'h0000;

  typedef enum logic [3:0] {
    OP_NOP, OP_CPWR, OP_CPRD, OP_LONG_CALL_OP, OP_LJUMP, OP_LIT, OP_COPY, OP_RETI,
    OP_RETLIT, OP_ROTR, OP_SUB, OP_SWAP, OP_TABLE, OP_TMODE, OP_XOR
  } mie_op_t;

  typedef struct packed {
    mie_op_t         op;
    logic            dest;
    logic [5:0]      faddr;
    logic [3:0]      cpaddr;
    logic [7:0]      lit;
    logic [PC_W-1:0] adr;
  } mie_dec_t;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } mie_flags_t;

  // Unknown words execute as no-operation
  function automatic mie_dec_t mie_decode(input logic [WORD_W-1:0] w);
    mie_dec_t d;
    d.op     = OP_NOP;
    d.dest   = w[6];
    d.faddr  = w[5:0];
    d.cpaddr = w[3:0];
    d.lit    = w[7:0];
    d.adr    = w[8:0];
    if (w[13:9] == ENC_LONG_CALL_OP) d.op = OP_LONG_CALL_OP;
    else if (w[13:9] == ENC_LJUMP) d.op = OP_LJUMP;
    else if (w[13:8] == ENC_LIT) d.op = OP_LIT;
    else if (w[13:8] == ENC_RETLIT) d.op = OP_RETLIT;
    else if (w[13:7] == ENC_COPY) d.op = OP_COPY;
    else if (w[13:7] == ENC_ROTR) d.op = OP_ROTR;
    else if (w[13:7] == ENC_SUB) d.op = OP_SUB;
    else if (w[13:7] == ENC_SWAP) d.op = OP_SWAP;
    else if (w[13:7] == ENC_XOR) d.op = OP_XOR;
    else if (w[13:4] == ENC_CPWR) d.op = OP_CPWR;
    else if (w[13:4] == ENC_CPRD) d.op = OP_CPRD;
    else if (w == ENC_RETI) d.op = OP_RETI;
    else if (w == ENC_TABLE) d.op = OP_TABLE;
    else if (w == ENC_TMODE) d.op = OP_TMODE;
    return d;
  endfunction
endpackage

// ==== tb/mie_prog_model.sv ====
// Program image side: builds instruction words for the core's program memory
`timescale 1ns/1ps
`default_nettype none
module mie_prog_model
  import mie_pkg::*;
;
  function automatic logic [WORD_W-1:0] f_lng(input logic call, input logic [PC_W-1:0] adr);
    return {(call ? ENC_LONG_CALL_OP : ENC_LJUMP), adr};
  endfunction

  function automatic logic [WORD_W-1:0] f_lit(input logic ret, input logic [7:0] v);
    return {(ret ? ENC_RETLIT : ENC_LIT), v};
  endfunction

  function automatic logic [WORD_W-1:0] f_alu(input logic [6:0] op, input logic d, input logic [5:0] r);
    return {op, d, r};
  endfunction

  function automatic logic [WORD_W-1:0] f_pg(input logic rd, input logic [3:0] f);
    return {(rd ? ENC_CPRD : ENC_CPWR), f};
  endfunction
endmodule
`default_nettype wire

// ==== tb/mie_core_assertions.sv ====
// Port-level checker for the instruction execute core
`timescale 1ns/1ps
`default_nettype none
module mie_core_assertions
  import mie_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              clk_en,
  input wire logic [BUS_AW-1:0] reg_addr,
  input wire logic [BUS_DW-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [BUS_DW-1:0] reg_rdata,
  input wire logic              global_irq_enable,
  input wire logic [DATA_W-1:0] timer_mode_reg
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Read data must not linger, a stale word would alias the next read
  rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == BUS_ZERO)
    else $error("read data present without a read");
  unmapped_read_a: assert property (reg_rd && clk_en && reg_addr > OFS_TMODE |=> reg_rdata == BUS_ZERO)
    else $error("unmapped read returned data");
  work_width_a: assert property (reg_rd && clk_en && reg_addr == OFS_WORK |=> reg_rdata[15:8] == 8'h00)
    else $error("work read has upper bits set");
  pc_width_a: assert property (reg_rd && clk_en && reg_addr == OFS_PC |=> reg_rdata[15:9] == 7'h00)
    else $error("pc read wider than nine bits");
  table_high_data_reg_width_a: assert property (reg_rd && clk_en && reg_addr == OFS_TABLE_HIGH_DATA_REG |=> reg_rdata[15:6] == 10'h000)
    else $error("table high data wider than six bits");
  tmode_mirror_a: assert property (reg_rd && clk_en && reg_addr == OFS_TMODE
    |=> reg_rdata == {8'h00, $past(timer_mode_reg)})
    else $error("timer mode read differs from port");
  gie_mirror_a: assert property (reg_rd && clk_en && reg_addr == OFS_FLAGS
    |=> reg_rdata[3] == $past(global_irq_enable) && reg_rdata[15:4] == 12'h000)
    else $error("flag read differs from interrupt enable");
  // No instruction of this subset clears the enable
  gie_sticky_a: assert property (!$fell(global_irq_enable))
    else $error("interrupt enable fell outside reset");
endmodule

bind mie_core mie_core_assertions chk_i (
  .ref_clk           (ref_clk),
  .rst_n             (rst_n),
  .clk_en            (clk_en),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_wr            (reg_wr),
  .reg_rd            (reg_rd),
  .reg_rdata         (reg_rdata),
  .global_irq_enable (global_irq_enable),
  .timer_mode_reg    (timer_mode_reg)
);
`default_nettype wire

// ==== tb/tb_mie_core.sv ====
// Self-checking bench for the instruction execute core
`timescale 1ns/1ps
`default_nettype none
module tb_mie_core
  import mie_pkg::*;
;
  logic              ref_clk;
  logic              rst_n;
  logic              clk_en;
  logic [BUS_AW-1:0] reg_addr;
  logic [BUS_DW-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [BUS_DW-1:0] reg_rdata;
  logic              global_irq_enable;
  logic [DATA_W-1:0] timer_mode_reg;
  logic [BUS_DW-1:0] rv;
  int                errors;
  int                num_checks;
  int                cycles;

  mie_core dut (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .clk_en            (clk_en),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .global_irq_enable (global_irq_enable),
    .timer_mode_reg    (timer_mode_reg)
  );
  mie_prog_model pm ();

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the whole run needs well under a thousand cycles
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [BUS_AW-1:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [BUS_AW-1:0] a, input logic [15:0] e);
    rd(a);
    chk(n, e, rv);
  endtask
  // Program words load only while halted
  task automatic rom(input logic [8:0] a, input logic [13:0] w);
    wr(OFS_PADDR, {7'h00, a});
    wr(OFS_PDATA, {2'h0, w});
  endtask
  task automatic run();
    wr(OFS_CTRL, 16'h0001);
    repeat (30) @(posedge ref_clk);
    wr(OFS_CTRL, BUS_ZERO);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_port();
    rchk("work_rst", OFS_WORK, BUS_ZERO);
    rchk("pc_rst", OFS_PC, BUS_ZERO);
    rchk("tmode_rst", OFS_TMODE, BUS_ZERO);
    rchk("unmapped", 4'hF, BUS_ZERO);
    // A write taken while the enable is low must leave no trace
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(OFS_TABLE_HIGH_POINTER, 16'h00FF);
    clk_en <= 1'b1;
    rchk("table_high_pointer_frozen", OFS_TABLE_HIGH_POINTER, BUS_ZERO);
    rom(9'h055, 14'h2ABC);
    wr(OFS_PADDR, 16'h0055);
    rchk("pdata", OFS_PDATA, 16'h2ABC);
  endtask
  task automatic test_page_literal();
    do_reset();
    rom(9'h000, pm.f_lit(1'b0, 8'hA5));
    rom(9'h001, ENC_TMODE);
    rom(9'h002, pm.f_pg(1'b0, CP_LO));
    rom(9'h003, pm.f_lit(1'b0, 8'h3C));
    rom(9'h004, pm.f_pg(1'b0, CP_HI));
    rom(9'h005, pm.f_pg(1'b1, CP_LO));
    rom(9'h006, pm.f_lng(1'b0, 9'h006));
    run();
    chk("tmode", 16'h00A5, {8'h00, timer_mode_reg});
    rchk("work", OFS_WORK, 16'h00A5);
    rchk("flags", OFS_FLAGS, BUS_ZERO);
    rchk("pc", OFS_PC, 16'h0006);
  endtask
  task automatic test_call_return();
    do_reset();
    rom(9'h000, pm.f_lng(1'b1, 9'h100));
    rom(9'h001, pm.f_lng(1'b1, 9'h1FF));
    rom(9'h002, pm.f_lng(1'b0, 9'h002));
    rom(9'h100, ENC_RETI);
    rom(9'h1FF, pm.f_lit(1'b1, 8'h5A));
    chk("gie_before", BUS_ZERO, {15'h0000, global_irq_enable});
    run();
    chk("gie", 16'h0001, {15'h0000, global_irq_enable});
    rchk("work", OFS_WORK, 16'h005A);
    rchk("pc", OFS_PC, 16'h0002);
  endtask
  // Pointer value 3 proves only its low bit reaches the address
  task automatic test_table();
    do_reset();
    rom(9'h134, 14'h35AA);
    rom(9'h000, pm.f_lit(1'b0, 8'h34));
    rom(9'h001, ENC_TABLE);
    rom(9'h002, pm.f_lng(1'b0, 9'h002));
    wr(OFS_TABLE_HIGH_POINTER, 16'h0003);
    run();
    rchk("work", OFS_WORK, 16'h00AA);
    rchk("table_high_data_reg", OFS_TABLE_HIGH_DATA_REG, 16'h0035);
    rchk("table_high_pointer", OFS_TABLE_HIGH_POINTER, 16'h0003);
  endtask
  // Chain through one file register; each result feeds the next step
  task automatic test_alu();
    do_reset();
    rom(9'h000, pm.f_lit(1'b0, 8'h06));
    rom(9'h001, pm.f_alu(ENC_XOR, 1'b1, 6'h05));
    rom(9'h002, pm.f_lit(1'b0, 8'h05));
    rom(9'h003, pm.f_alu(ENC_SUB, 1'b1, 6'h05));
    rom(9'h004, pm.f_alu(ENC_ROTR, 1'b1, 6'h05));
    rom(9'h005, pm.f_alu(ENC_ROTR, 1'b1, 6'h05));
    rom(9'h006, pm.f_alu(ENC_SWAP, 1'b1, 6'h05));
    rom(9'h007, pm.f_alu(ENC_COPY, 1'b0, 6'h05));
    rom(9'h008, pm.f_alu(ENC_XOR, 1'b1, 6'h05));
    rom(9'h009, pm.f_lng(1'b0, 9'h009));
    run();
    rchk("work", OFS_WORK, 16'h000C);
    rchk("flags", OFS_FLAGS, 16'h0006);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = BUS_ZERO;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    errors = 0;
    num_checks = 0;
    cycles = 0;
    do_reset();
    test_port();
    test_page_literal();
    test_call_return();
    test_table();
    test_alu();
    give_verdict();
  end
endmodule
`default_nettype wire
